/* core/aabc_core.sv */
// Purpose: Add and bit-clear datapath with an AHB-Lite register port.
// Assumes: Single master, single word transfers, 10 MHz hclk.
// Notes: A command write executes in the following single cycle.
//
// Notes on behaviour
// [RL1] Add with carry: file plus work plus carry.
// [RL2] Plain add of work and file register.
// [RL3] Immediate add with carry into work register.
// [RL4] Immediate add without carry into work.
// [RL5] AND updates zero only, one cycle.
// [RL6] Destination bit zero: work; one: file. Only register adds and AND follow it; immediates write work, clear the file.
// [RL7] Bit clear touches one bit, no flags.
// [RL8] Carry flag equals carry out of sum.
// [RL9] Zero on zero result; half carry bit3.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "aabc_consts.svh"
module aabc_core #(
	parameter int DEPTH = `AABC_FILE_DEPTH
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	aabc_pkg::aabc_byte_t file_reg [DEPTH]; // File registers.
	aabc_pkg::aabc_byte_t work_reg; // Work register.
	aabc_pkg::aabc_byte_t oper_reg; // Immediate operand.
	logic zero_reg; // Zero flag.
	logic nibble_overflow_flag_reg; // Half carry flag.
	logic carry_reg; // Carry flag.
	logic [31:0] cmd_reg; // Last command word.
	aabc_pkg::aabc_state_e state_reg; // Execution state.
	// Address phase capture.
	logic wr_pend_reg; // A write data phase is in progress.
	logic [31:0] addr_reg; // Address of the transfer in its data phase.
	logic [31:0] rdata_reg; // Read data, held until the next transfer.
	logic hreadyout_reg; // Ready output, always high (no wait states).
	logic hresp_reg; // Response output, always OKAY.
	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// A transfer is taken only when selected, NONSEQ and bus ready.
	wire take = hsel & hready & (htrans == `AABC_TRANS_NONSEQ);
	wire [31:0] a = haddr;
	// True for a byte address inside the file register window; both the
	// read decode and the write decode use it, so the bounds live once.
	function automatic logic in_file_window(input logic [31:0] x);
		return (x >= `AABC_OFF_FILE) && (x <= `AABC_OFF_FILE_END);
	endfunction
	wire hit_file = in_file_window(a); // Read targets a file register.
	wire [5:0] a_idx = a[7:2]; // File index for a read.
	wire [5:0] w_idx = addr_reg[7:2]; // File index for a write.
	wire w_file = in_file_window(addr_reg); // Write targets the file.
	wire w_cmd = wr_pend_reg && (addr_reg == `AABC_OFF_CMD);
	// Read data for the addressed word; unmapped reads as zero.
	logic [31:0] rd_val;
	always_comb begin
		if (a == `AABC_OFF_CMD) begin
			rd_val = cmd_reg;
		end else if (a == `AABC_OFF_OPER) begin
			rd_val = {24'h0, oper_reg};
		end else if (a == `AABC_OFF_WORK) begin
			rd_val = {24'h0, work_reg};
		end else if (a == `AABC_OFF_FLAGS) begin
			rd_val = {29'h0, carry_reg, nibble_overflow_flag_reg, zero_reg};
		end else if (hit_file) begin
			rd_val = {24'h0, file_reg[a_idx]};
		end else begin
			rd_val = 32'h0;
		end
	end
	// ----------------------------------------------------------------
	// Command fields and ALU
	// ----------------------------------------------------------------
	aabc_op_if opl ();
	aabc_alu u_alu (
		.p(opl)
	);
	wire exec = (state_reg == aabc_pkg::AABC_ST_EXEC);
	wire [2:0] op_bits = cmd_reg[`AABC_OPC_LSB +: 3];
	wire dest = cmd_reg[`AABC_DEST_BIT];
	wire [5:0] r_idx = cmd_reg[`AABC_ADDR_LSB +: 6];
	wire is_imm = (op_bits == 3'(aabc_pkg::AABC_OP_ADD_IMM_WITH_CARRY)) ||
		(op_bits == 3'(aabc_pkg::AABC_OP_ADD_IMM));
	wire is_clr = (op_bits == 3'(aabc_pkg::AABC_OP_CLEAR_REG_BIT));
	assign opl.op = exec ? aabc_pkg::aabc_op_e'(op_bits) :
		aabc_pkg::AABC_OP_NONE;
	assign opl.work = work_reg;
	assign opl.operand = is_imm ? oper_reg : file_reg[r_idx];
	assign opl.bit_sel = cmd_reg[`AABC_BIT_LSB +: 3];
	assign opl.carry_in = carry_reg;
	wire op_valid = exec && (op_bits != 3'h0) && (op_bits != 3'h7);
	// Immediate forms always write work; clear always writes the file.
	// The select bit is ignored by those forms, as software expects.
	wire to_file = op_valid && !is_imm && (is_clr || dest); // [RL6]
	wire to_work = op_valid && !is_imm ? !is_clr && !dest : op_valid; // [RL6]
	// ----------------------------------------------------------------
	// Bus pipeline
	// ----------------------------------------------------------------
	// Zero wait states; reads are captured in the address phase. The
	// ready and response flops never change after reset, but they keep
	// every bus output on a register so no decode path reaches a pin.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 32'h0;
			rdata_reg <= 32'h0;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
		end else begin
			wr_pend_reg <= take & hwrite;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			if (take) begin
				addr_reg <= a;
				rdata_reg <= rd_val;
			end
		end
	end
	// ----------------------------------------------------------------
	// Execution sequencing
	// ----------------------------------------------------------------
	// A command write arms exactly one execution cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= aabc_pkg::AABC_ST_IDLE;
			cmd_reg <= 32'h0;
		end else begin
			state_reg <= w_cmd ? aabc_pkg::AABC_ST_EXEC :
				aabc_pkg::AABC_ST_IDLE; // [RL1] [RL2] [RL5] [RL7]
			if (w_cmd) begin
				cmd_reg <= hwdata;
			end
		end
	end
	// ----------------------------------------------------------------
	// Work register, operand and flags
	// ----------------------------------------------------------------
	// Execution results win over a bus write in the same cycle.
	// A flag that the operation leaves alone may still take the bus
	// write, so software can preset carry before a with-carry add.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			work_reg <= `AABC_RST_BYTE;
			oper_reg <= `AABC_RST_BYTE;
			zero_reg <= 1'b0;
			nibble_overflow_flag_reg <= 1'b0;
			carry_reg <= 1'b0;
		end else begin
			if (to_work) begin
				work_reg <= opl.result; // [RL3] [RL4] [RL6]
			end else if (wr_pend_reg && addr_reg == `AABC_OFF_WORK) begin
				work_reg <= hwdata[7:0];
			end
			if (wr_pend_reg && addr_reg == `AABC_OFF_OPER) begin
				oper_reg <= hwdata[7:0];
			end
			if (op_valid && opl.set_zc) begin
				zero_reg <= opl.zero; // [RL9]
			end else if (wr_pend_reg && addr_reg == `AABC_OFF_FLAGS) begin
				zero_reg <= hwdata[`AABC_FLAG_Z];
			end
			if (op_valid && opl.set_nc) begin
				nibble_overflow_flag_reg <= opl.nib; // [RL9]
				carry_reg <= opl.carry; // [RL8]
			end else if (wr_pend_reg && addr_reg == `AABC_OFF_FLAGS) begin
				nibble_overflow_flag_reg <= hwdata[`AABC_FLAG_NIB];
				carry_reg <= hwdata[`AABC_FLAG_C];
			end
		end
	end
	// ----------------------------------------------------------------
	// File registers
	// ----------------------------------------------------------------
	// An operation that writes the file owns it for its one cycle; a bus
	// write to the file in that cycle is dropped rather than merged.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				file_reg[i] <= `AABC_RST_BYTE;
			end
		end else if (to_file) begin
			file_reg[r_idx] <= opl.result; // [RL6] [RL7]
		end else if (wr_pend_reg && w_file) begin
			file_reg[w_idx] <= hwdata[7:0];
		end
	end
	// ----------------------------------------------------------------
	// Bus outputs
	// ----------------------------------------------------------------
	assign hrdata = rdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = hresp_reg;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Every check but a_exec_one_cycle looks one cycle after the execution
	// cycle, where the result has just landed. Sums and carry flags are
	// rebuilt from the operands with plain arithmetic rather than taken from
	// the nibble adders, so a slip in the carry chain shows up here; the
	// routing and zero flag checks compare against opl.result itself.
	// A bus write that lands in the execution cycle is not covered: the
	// execution result wins there, and the checks assume a quiet bus.
	// Operations decoded for the checks, qualified by the exec cycle.
	wire run_adc_reg = exec &&
		(op_bits == 3'(aabc_pkg::AABC_OP_ADD_REG_WITH_CARRY));
	wire run_add_reg = exec &&
		(op_bits == 3'(aabc_pkg::AABC_OP_ADD_REG));
	wire run_adc_imm = exec &&
		(op_bits == 3'(aabc_pkg::AABC_OP_ADD_IMM_WITH_CARRY));
	wire run_add_imm = exec &&
		(op_bits == 3'(aabc_pkg::AABC_OP_ADD_IMM));
	wire run_and_reg = exec &&
		(op_bits == 3'(aabc_pkg::AABC_OP_AND_REG));
	wire run_clr_bit = exec && is_clr;
	// A command write gives one execution cycle; only a second command
	// write straight after it may bring a second one.
	a_exec_one_cycle: assert property ( // [RL1]
		@(posedge hclk) disable iff (!hresetn)
		w_cmd |=> exec ##1 (!exec || $past(w_cmd)))
		else $error("execution did not last one cycle");
	// Register add with carry folds the carry flag into the sum.
	a_add_reg_carry: assert property ( // [RL1]
		@(posedge hclk) disable iff (!hresetn)
		run_adc_reg && dest |=> file_reg[$past(r_idx)] ==
		8'($past(work_reg) + $past(opl.operand) +
		{7'h0, $past(carry_reg)}))
		else $error("register add with carry wrong");
	// With the select bit clear the sum goes to the work register.
	a_dest_work: assert property ( // [RL6]
		@(posedge hclk) disable iff (!hresetn)
		run_adc_reg && !dest |=> work_reg == $past(opl.result))
		else $error("result not routed to work");
	// With the select bit set the file register takes the sum and the
	// work register keeps its value.
	a_dest_file: assert property ( // [RL2]
		@(posedge hclk) disable iff (!hresetn)
		run_add_reg && dest |=> file_reg[$past(r_idx)] ==
		$past(opl.result) && $stable(work_reg))
		else $error("result not routed to file");
	// Plain register add: carry flag is the ninth bit of the sum.
	a_carry_out: assert property ( // [RL8]
		@(posedge hclk) disable iff (!hresetn)
		run_add_reg |=> carry_reg == (({1'b0, $past(work_reg)} +
		{1'b0, $past(opl.operand)}) > 9'h0ff))
		else $error("carry flag wrong after add");
	// Half carry of the carry-free adds, from the low nibbles alone.
	a_nibble_flag: assert property ( // [RL9]
		@(posedge hclk) disable iff (!hresetn)
		run_add_reg || run_add_imm |=> nibble_overflow_flag_reg ==
		(({1'b0, $past(work_reg[3:0])} +
		{1'b0, $past(opl.operand[3:0])}) > 5'h0f))
		else $error("half carry flag wrong");
	// Immediate add with carry lands in the work register.
	a_add_carry: assert property ( // [RL3]
		@(posedge hclk) disable iff (!hresetn)
		run_adc_imm |=> work_reg == 8'($past(work_reg) +
		$past(oper_reg) + {7'h0, $past(carry_reg)}))
		else $error("immediate add with carry wrong");
	// Immediate forms ignore the select bit, so no file register moves.
	a_imm_keeps_file: assert property ( // [RL3]
		@(posedge hclk) disable iff (!hresetn)
		run_adc_imm |=> file_reg[$past(r_idx)] == $past(file_reg[r_idx]))
		else $error("immediate add wrote a file register");
	// Immediate add ignores whatever the carry flag holds.
	a_add_plain: assert property ( // [RL4]
		@(posedge hclk) disable iff (!hresetn)
		run_add_imm |=> work_reg == 8'($past(work_reg) + $past(oper_reg)))
		else $error("immediate add result wrong");
	// AND forms the bitwise product of work and file register.
	a_and_result: assert property ( // [RL5]
		@(posedge hclk) disable iff (!hresetn)
		run_and_reg && !dest |=> work_reg ==
		($past(work_reg) & $past(opl.operand)))
		else $error("and result wrong");
	// AND leaves both carry flags exactly as they were.
	a_and_keeps: assert property ( // [RL5]
		@(posedge hclk) disable iff (!hresetn)
		run_and_reg |=> $stable(carry_reg) &&
		$stable(nibble_overflow_flag_reg))
		else $error("and changed carry flags");
	// Bit clear zeroes the chosen bit and touches no flag.
	a_clear_bit: assert property ( // [RL7]
		@(posedge hclk) disable iff (!hresetn)
		run_clr_bit |=> file_reg[$past(r_idx)][$past(opl.bit_sel)] == 1'b0
		&& $stable(zero_reg) && $stable(carry_reg) &&
		$stable(nibble_overflow_flag_reg))
		else $error("bit clear wrong");
	// Bit clear changes that one bit only, and only if it was set.
	a_clear_others: assert property ( // [RL7]
		@(posedge hclk) disable iff (!hresetn)
		run_clr_bit |=> (file_reg[$past(r_idx)] ^ $past(opl.operand)) ==
		($past(opl.operand) & (8'h01 << $past(opl.bit_sel))))
		else $error("bit clear changed other bits");
	// Zero flag follows every result that is allowed to write it.
	a_zero_flag: assert property ( // [RL9]
		@(posedge hclk) disable iff (!hresetn)
		op_valid && opl.set_zc |=> zero_reg == ($past(opl.result) == 8'h00))
		else $error("zero flag wrong");
endmodule

/* core/aabc_consts.svh */
// Purpose: Named constants for the add and bit-clear datapath.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef AABC_CONSTS_SVH
`define AABC_CONSTS_SVH
`define AABC_OFF_CMD 32'h0000_0000
`define AABC_OFF_OPER 32'h0000_0004
`define AABC_OFF_WORK 32'h0000_0008
`define AABC_OFF_FLAGS 32'h0000_000c
`define AABC_OFF_FILE 32'h0000_0100
`define AABC_OFF_FILE_END 32'h0000_01fc
`define AABC_FILE_DEPTH 64
`define AABC_OPC_LSB 0
`define AABC_DEST_BIT 4
`define AABC_ADDR_LSB 8
`define AABC_BIT_LSB 16
`define AABC_FLAG_Z 0
`define AABC_FLAG_NIB 1
`define AABC_FLAG_C 2
`define AABC_NIB_BIT 4
`define AABC_RST_BYTE 8'h00
`define AABC_TRANS_NONSEQ 2'h2
`define AABC_EXEC_CYCLES 1
`endif

/* core/aabc_pkg.sv */
// Purpose: Types shared by the add and bit-clear datapath.
// Assumes: Nothing.
// Notes: Constants live in aabc_consts.svh.
package aabc_pkg;
	// Operation select codes.
	typedef enum logic [2:0] {
		AABC_OP_NONE = 3'h0,
		AABC_OP_ADD_REG_WITH_CARRY = 3'h1,
		AABC_OP_ADD_REG = 3'h2,
		AABC_OP_ADD_IMM_WITH_CARRY = 3'h3,
		AABC_OP_ADD_IMM = 3'h4,
		AABC_OP_AND_REG = 3'h5,
		AABC_OP_CLEAR_REG_BIT = 3'h6
	} aabc_op_e;
	// Execution state, Gray coded.
	typedef enum logic [1:0] {
		AABC_ST_IDLE = 2'h0,
		AABC_ST_EXEC = 2'h1
	} aabc_state_e;
	typedef logic [7:0] aabc_byte_t;
endpackage

/* core/aabc_op_if.sv */
// Purpose: Carries one operation between control and the ALU.
// Assumes: Single clock.
// Notes: Pure combinational link.
`timescale 1ns/100ps
interface aabc_op_if;
	aabc_pkg::aabc_op_e op; // Operation to perform.
	aabc_pkg::aabc_byte_t work; // Work register value.
	aabc_pkg::aabc_byte_t operand; // File byte or immediate.
	logic [2:0] bit_sel; // Bit position for clear.
	logic carry_in; // Current carry flag.
	aabc_pkg::aabc_byte_t result; // Computed byte.
	logic zero; // Result is zero.
	logic nib; // Carry out of bit 3.
	logic carry; // Carry out of bit 7.
	logic set_zc; // Update zero flag.
	logic set_nc; // Update nibble and carry flags.
	modport ctrl (output op, work, operand, bit_sel, carry_in,
		input result, zero, nib, carry, set_zc, set_nc);
	modport alu (input op, work, operand, bit_sel, carry_in,
		output result, zero, nib, carry, set_zc, set_nc);
endinterface

/* core/aabc_alu.sv */
// Purpose: Combinational arithmetic for the supported operations.
// Assumes: Operands stable for the execution cycle.
// Notes: Flag enables tell the caller which flags to write.
`timescale 1ns/100ps
`include "aabc_consts.svh"
module aabc_alu (
	aabc_op_if.alu p
);
	// ----------------------------------------------------------------
	// Adders
	// ----------------------------------------------------------------
	// Carry in is used only by the two with-carry forms.
	wire use_cin = (p.op == aabc_pkg::AABC_OP_ADD_REG_WITH_CARRY) ||
		(p.op == aabc_pkg::AABC_OP_ADD_IMM_WITH_CARRY);
	wire cin = use_cin & p.carry_in;
	wire is_add = use_cin || (p.op == aabc_pkg::AABC_OP_ADD_REG) ||
		(p.op == aabc_pkg::AABC_OP_ADD_IMM);
	// Low nibble sum gives the half carry.
	wire [4:0] lo_sum = {1'b0, p.work[3:0]} + {1'b0, p.operand[3:0]} +
		{4'h0, cin};
	wire [4:0] hi_sum = {1'b0, p.work[7:4]} + {1'b0, p.operand[7:4]} +
		{4'h0, lo_sum[`AABC_NIB_BIT]};
	wire [7:0] sum = {hi_sum[3:0], lo_sum[3:0]};
	wire [7:0] clr_mask = ~(8'h01 << p.bit_sel); // [RL7]
	// ----------------------------------------------------------------
	// Result selection
	// ----------------------------------------------------------------
	assign p.result = is_add ? sum : // [RL1] [RL2] [RL3] [RL4]
		(p.op == aabc_pkg::AABC_OP_AND_REG) ? (p.work & p.operand) : // [RL5]
		(p.operand & clr_mask); // [RL7]
	assign p.zero = (p.result == `AABC_RST_BYTE); // [RL9]
	assign p.nib = lo_sum[`AABC_NIB_BIT]; // [RL9]
	assign p.carry = hi_sum[`AABC_NIB_BIT]; // [RL8]
	assign p.set_zc = is_add || (p.op == aabc_pkg::AABC_OP_AND_REG);
	assign p.set_nc = is_add; // [RL5]
endmodule

/* verif/add_and_bitclear_alu_ops_tb.sv */
// Purpose: Self-checking bench for the add and bit-clear datapath.
// Assumes: Zero-wait AHB-Lite slave, command executes after data phase.
// Notes: Every operation is staged through registers, then read back.
`timescale 1ns/100ps
`include "aabc_consts.svh"
module add_and_bitclear_alu_ops_tb;
	logic hclk; // Bus clock, 100 ns period.
	logic hresetn; // Active-low asynchronous reset.
	logic hsel; // Slave select.
	logic [31:0] haddr; // Byte address.
	logic [1:0] htrans; // Transfer kind.
	logic hwrite; // Write strobe.
	logic [2:0] hsize; // Always a word.
	logic [31:0] hwdata; // Write data.
	logic [31:0] hrdata; // Read data.
	logic hreadyout; // Slave ready.
	logic hresp; // Slave response.
	wire hready = hreadyout; // One slave, so its ready is the bus ready.
	int n_errors; // Mismatches seen.
	int compares; // Comparisons made.

	aabc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));

	// -----------------------------------------------------------
	// Clock
	// -----------------------------------------------------------
	// Free-running clock, inverted every half period.
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// -----------------------------------------------------------
	// Reporting
	// -----------------------------------------------------------
	// Single exit point of the run.
	task automatic give_verdict;
		if (n_errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Compares with case equality so an unknown never matches.
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// -----------------------------------------------------------
	// Bus tasks
	// -----------------------------------------------------------
	// Waits for the next edge with ready high; bounded so a hang ends.
	task automatic wait_ready;
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			i++;
			if (i > 100) begin
				n_errors++;
				$display("FAIL hready expected 1 seen %b", hready);
				give_verdict();
			end
			@(posedge hclk);
		end
	endtask

	// One single transfer; entered just after a rising edge.
	task automatic ahb_xfer(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		haddr <= a;
		hwrite <= wr;
		htrans <= `AABC_TRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0000_0000);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] unused;
		ahb_xfer(1'b1, a, d, unused);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		ahb_xfer(1'b0, a, 32'h0000_0000, d);
	endtask

	// -----------------------------------------------------------
	// Operation runner
	// -----------------------------------------------------------
	// Stages operands, issues one command, then checks both possible
	// destinations so a result landing in the wrong place is caught.
	task automatic run_case(input logic [2:0] op, input logic dest,
		input logic [5:0] idx, input logic [2:0] bt, input logic [7:0] w,
		input logic [7:0] f, input logic [7:0] imm, input logic [2:0] fl,
		input logic [7:0] er, input logic [2:0] efl);
		logic to_file;
		logic [31:0] fa;
		logic [31:0] v;
		to_file = (op == 3'h6) || (dest && (op == 3'h1 || op == 3'h2 ||
			op == 3'h5));
		fa = `AABC_OFF_FILE + {24'h0, idx, 2'h0};
		wr(`AABC_OFF_WORK, {24'h0, w});
		wr(fa, {24'h0, f});
		wr(`AABC_OFF_OPER, {24'h0, imm});
		wr(`AABC_OFF_FLAGS, {29'h0, fl});
		wr(`AABC_OFF_CMD, {13'h0, bt, 2'h0, idx, 3'h0, dest, 1'h0, op});
		// Execution plus settling margin before reading back.
		repeat (2) @(posedge hclk);
		rd(`AABC_OFF_WORK, v);
		check("work", v, {24'h0, to_file ? w : er});
		rd(fa, v);
		check("file", v, {24'h0, to_file ? er : f});
		rd(`AABC_OFF_FLAGS, v);
		check("flags", v, {29'h0, efl});
	endtask

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		logic [31:0] v;
		n_errors = 0;
		compares = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset state and an unmapped place both read as zero.
		rd(`AABC_OFF_WORK, v);
		check("work_rst", v, 32'h0000_0000);
		rd(`AABC_OFF_FILE_END, v);
		check("file_rst", v, 32'h0000_0000);
		rd(`AABC_OFF_FILE_END + 32'h0000_0004, v);
		check("unmapped", v, 32'h0000_0000);
		// Columns: op dest idx bit work file imm flags result flags.
		run_case(3'h1,1'h0,6'h01,3'h0,8'hff,8'h00,8'h00,3'h4,8'h00,3'h7);
		run_case(3'h1,1'h1,6'h02,3'h0,8'h12,8'h34,8'h00,3'h4,8'h47,3'h0);
		run_case(3'h2,1'h1,6'h02,3'h0,8'h12,8'h34,8'h00,3'h4,8'h46,3'h0);
		run_case(3'h2,1'h0,6'h03,3'h0,8'h0f,8'h01,8'h00,3'h1,8'h10,3'h2);
		run_case(3'h3,1'h1,6'h04,3'h0,8'h12,8'h55,8'h34,3'h4,8'h47,3'h0);
		run_case(3'h4,1'h0,6'h04,3'h0,8'h80,8'h55,8'h80,3'h4,8'h00,3'h5);
		run_case(3'h4,1'h0,6'h04,3'h0,8'h99,8'h55,8'h77,3'h0,8'h10,3'h6);
		run_case(3'h5,1'h1,6'h05,3'h0,8'h5a,8'haf,8'h00,3'h7,8'h0a,3'h6);
		run_case(3'h5,1'h0,6'h06,3'h0,8'h0f,8'hf0,8'h00,3'h6,8'h00,3'h7);
		run_case(3'h6,1'h0,6'h3f,3'h3,8'h11,8'h5a,8'h00,3'h5,8'h52,3'h5);
		run_case(3'h6,1'h1,6'h00,3'h7,8'h22,8'hff,8'h00,3'h2,8'h7f,3'h2);
		// An undefined code leaves every register and flag alone.
		run_case(3'h7,1'h0,6'h07,3'h0,8'h3c,8'hc3,8'h00,3'h5,8'h3c,3'h5);
		// Back-to-back commands: the second consumes the first's carry.
		wr(`AABC_OFF_WORK, 32'h0000_00f0);
		wr(`AABC_OFF_OPER, 32'h0000_0020);
		wr(`AABC_OFF_FLAGS, 32'h0000_0000);
		wr(`AABC_OFF_CMD, 32'h0000_0004);
		wr(`AABC_OFF_CMD, 32'h0000_0003);
		repeat (2) @(posedge hclk);
		rd(`AABC_OFF_WORK, v);
		check("chain_work", v, 32'h0000_0031);
		rd(`AABC_OFF_FLAGS, v);
		check("chain_flags", v, 32'h0000_0000);
		give_verdict();
	end
endmodule
